// ---- pcp_map.svh ----
// Register offsets, field positions, reset values and write masks of the pump and detector bank
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

`define PCP_ADDR_W          13
`define PCP_NUM_REGS        4
`define PCP_IDX_W           2

// Register offsets
`define PCP_OFS_CURRENT     13'h000A
`define PCP_OFS_CONTROL     13'h000B
`define PCP_OFS_TESTDIV     13'h000C
`define PCP_OFS_BACKLASH    13'h000D

// Bank indices
`define PCP_IDX_CURRENT     2'h0
`define PCP_IDX_CONTROL     2'h1
`define PCP_IDX_TESTDIV     2'h2
`define PCP_IDX_BACKLASH    2'h3

// Reset values
`define PCP_RST_CURRENT     8'h80
`define PCP_RST_CONTROL     8'h30
`define PCP_RST_TESTDIV     8'h00
`define PCP_RST_BACKLASH    8'h00

// Writable bits; all other bits read zero
`define PCP_WM_CURRENT      8'hFF
`define PCP_WM_CONTROL      8'hFF
`define PCP_WM_TESTDIV      8'h07
`define PCP_WM_BACKLASH     8'hC1

// Control register fields
`define PCP_CTL_CUR_OVR     7
`define PCP_CTL_ABL_OVR     6
`define PCP_CTL_MODE_HI     5
`define PCP_CTL_MODE_LO     4
`define PCP_CTL_DISABLE     3
`define PCP_CTL_FB_EDGE     2
`define PCP_CTL_REF_EDGE    1
`define PCP_CTL_VCO_MID     0

// Test divider fields
`define PCP_TD_HI           2
`define PCP_TD_LO           0
`define PCP_TD_FB           0
`define PCP_TD_REF          1
`define PCP_TD_UP           2
`define PCP_TD_ALL          3'h7

// Test divider enable vector, bit order fb, ref, up, dn
`define PCP_DIV_W           4
`define PCP_DIV_FB          0
`define PCP_DIV_REF         1
`define PCP_DIV_UP          2
`define PCP_DIV_DN          3
`define PCP_DIV_NONE        4'h0
`define PCP_DIV_ALL_SET     4'hD

// Backlash register fields
`define PCP_ABL_HI          7
`define PCP_ABL_LO          6
`define PCP_LD_PD           0

`define PCP_BYTE_ZERO       8'h00

`endif

// ---- pcp_pkg.sv ----
// Types shared by the pump and detector control bank
`default_nettype none
package pcp_pkg;

    // Charge pump mode, ordered to match the 2-bit field encoding
    typedef enum logic [1:0] {
        PCP_MODE_TRISTATE,
        PCP_MODE_PUMP_UP,
        PCP_MODE_PUMP_DOWN,
        PCP_MODE_NORMAL
    } pcp_pump_mode_t;

    // Antibacklash period, ordered to match the 2-bit field encoding
    typedef enum logic [1:0] {
        PCP_ABL_MINIMUM,
        PCP_ABL_LOW,
        PCP_ABL_HIGH,
        PCP_ABL_MAXIMUM
    } pcp_backlash_t;

endpackage : pcp_pkg
`default_nettype wire

// ---- pcp_reg_pair.sv ----
// One buffered register: serial-port buffer byte plus the active byte loaded on update
`timescale 1ns/1ps
`default_nettype none
module pcp_reg_pair #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WMASK   = 8'hFF
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Write and update
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic       update,
    // Contents
    output logic      [7:0] buf_q,
    output logic      [7:0] act_q
);

    logic [7:0] buf_ff;
    logic [7:0] act_ff;
    logic [7:0] nxt_buf;
    logic [7:0] nxt_act;

    // Unused bits are masked so they never store a one
    always_comb begin
        nxt_buf = buf_ff;
        nxt_act = act_ff;
        if (wr) begin
            nxt_buf = wdata & WMASK;
        end
        // Update copies the buffer as it stood before any same-cycle write
        if (update) begin
            nxt_act = buf_ff;
        end
    end

    // Register stage, frozen while the clock enable is low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buf_ff <= RST_VAL;
            act_ff <= RST_VAL;
        end else if (ce) begin
            buf_ff <= nxt_buf;
            act_ff <= nxt_act;
        end
    end

    assign buf_q = buf_ff;
    assign act_q = act_ff;

endmodule : pcp_reg_pair
`default_nettype wire

// ---- pcp_regs.sv ----
// Charge pump and phase detector control register bank with buffered update
// What this block does
// - Hold 8-bit pump current code, default 0x80
// - Override bit picks code, else strap lookup
// - Antibacklash override picks field, else automatic
// - Mode field: tristate, up, down, normal
// - Disable bit forces tristate mode
// - Feedback active edge: 0 rising, 1 falling
// - Reference active edge: 0 rising, 1 falling
// - Force oscillator control voltage to midscale
// - Test field divides detector clocks by two
// - Antibacklash period minimum, low, high, maximum
// - Lock detector power-down bit
// - Buffered values apply only on update
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module pcp_regs (
    // Clock, reset, enable
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // Register access from the serial port engine
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`PCP_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    output logic                        reg_hit,
    // Serial port control
    input  wire logic                   io_update,
    input  wire logic                   readback_buffered,
    // Values from the pin-driven frequency logic
    input  wire logic [7:0]             pin_table_current,
    input  wire logic [1:0]             auto_backlash,
    // Analog controls
    output logic      [7:0]             cp_current,
    output logic      [1:0]             cp_mode,
    output logic                        fb_edge_falling,
    output logic                        ref_edge_falling,
    output logic                        vco_force_mid,
    output logic                        div_fb,
    output logic                        div_ref,
    output logic                        div_up,
    output logic                        div_dn,
    output logic      [1:0]             backlash_sel,
    output logic                        lock_det_pd
);

    // Reset values and write masks, indexed in bank order
    localparam logic [7:0] RST_TAB [`PCP_NUM_REGS] = '{
        `PCP_RST_CURRENT,
        `PCP_RST_CONTROL,
        `PCP_RST_TESTDIV,
        `PCP_RST_BACKLASH
    };
    localparam logic [7:0] WM_TAB  [`PCP_NUM_REGS] = '{
        `PCP_WM_CURRENT,
        `PCP_WM_CONTROL,
        `PCP_WM_TESTDIV,
        `PCP_WM_BACKLASH
    };

    // Buffer and active views of every register
    logic [7:0]            buf_q [`PCP_NUM_REGS];
    logic [7:0]            act_q [`PCP_NUM_REGS];
    logic                  addr_hit;
    logic [`PCP_IDX_W-1:0] addr_idx;
    logic [`PCP_ADDR_W-1:0] addr_ofs;

    // Address decode; the bank occupies four consecutive offsets
    // Offsets below the bank wrap in the subtraction, so the range test
    // is what keeps such addresses from aliasing onto a bank index
    always_comb begin
        addr_ofs = reg_addr - `PCP_OFS_CURRENT;
        addr_hit = (reg_addr >= `PCP_OFS_CURRENT) && (reg_addr <= `PCP_OFS_BACKLASH);
        addr_idx = addr_ofs[`PCP_IDX_W-1:0];
    end

    // One buffer/active pair per register
    genvar gi;
    generate
        for (gi = 0; gi < `PCP_NUM_REGS; gi = gi + 1) begin : g_reg
            pcp_reg_pair #(
                .RST_VAL (RST_TAB[gi]),
                .WMASK   (WM_TAB[gi])
            ) u_pair (
                .mclk   (mclk),
                .rst_n  (rst_n),
                .ce     (ce),
                .wr     (reg_wr && addr_hit && (addr_idx == `PCP_IDX_W'(gi))),
                .wdata  (reg_wdata),
                .update (io_update),
                .buf_q  (buf_q[gi]),
                .act_q  (act_q[gi])
            );
        end
    endgenerate

    // Read path state
    logic [7:0] rdata_ff;
    logic       rvalid_ff;
    logic       hit_ff;
    logic [7:0] nxt_rdata;
    logic       nxt_rvalid;
    logic       nxt_hit;

    // Readback picks buffer or active copy; unmapped offsets answer zero
    // A same-cycle write is not seen: the read returns the byte before the edge
    always_comb begin
        nxt_rdata  = `PCP_BYTE_ZERO;
        nxt_rvalid = reg_rd;
        nxt_hit    = reg_rd && addr_hit;
        if (reg_rd && addr_hit) begin
            nxt_rdata = readback_buffered ? buf_q[addr_idx] : act_q[addr_idx];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_ff  <= `PCP_BYTE_ZERO;
            rvalid_ff <= 1'b0;
            hit_ff    <= 1'b0;
        end else if (ce) begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            hit_ff    <= nxt_hit;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign reg_hit    = hit_ff;

    // Control output state
    logic [7:0] cur_ff;
    logic [1:0] mode_ff;
    logic       fb_edge_ff;
    logic       ref_edge_ff;
    logic       vco_mid_ff;
    logic [`PCP_DIV_W-1:0] div_ff;
    logic [1:0] abl_ff;
    logic       ld_pd_ff;
    logic [7:0] nxt_cur;
    logic [1:0] nxt_mode;
    logic       nxt_fb_edge;
    logic       nxt_ref_edge;
    logic       nxt_vco_mid;
    logic [`PCP_DIV_W-1:0] nxt_div;
    logic [1:0] nxt_abl;
    logic       nxt_ld_pd;
    logic [7:0] ctl;
    logic [2:0] td;

    // Derive the analog controls from the active copies and the pin-side values, never the buffers
    always_comb begin
        ctl = act_q[`PCP_IDX_CONTROL];
        td  = act_q[`PCP_IDX_TESTDIV][`PCP_TD_HI:`PCP_TD_LO];
        nxt_cur = ctl[`PCP_CTL_CUR_OVR] ? act_q[`PCP_IDX_CURRENT]
                                        : pin_table_current;
        nxt_mode = ctl[`PCP_CTL_MODE_HI:`PCP_CTL_MODE_LO];
        if (ctl[`PCP_CTL_DISABLE]) begin
            nxt_mode = pcp_pkg::PCP_MODE_TRISTATE;
        end
        nxt_fb_edge  = ctl[`PCP_CTL_FB_EDGE];
        nxt_ref_edge = ctl[`PCP_CTL_REF_EDGE];
        nxt_vco_mid  = ctl[`PCP_CTL_VCO_MID];
        // Code 111 is irregular: it adds pump-down and drops reference
        if (td == `PCP_TD_ALL) begin
            nxt_div = `PCP_DIV_ALL_SET;
        end else begin
            nxt_div = `PCP_DIV_NONE;
            nxt_div[`PCP_DIV_FB]  = td[`PCP_TD_FB];
            nxt_div[`PCP_DIV_REF] = td[`PCP_TD_REF];
            nxt_div[`PCP_DIV_UP]  = td[`PCP_TD_UP];
        end
        nxt_abl = ctl[`PCP_CTL_ABL_OVR]
                ? act_q[`PCP_IDX_BACKLASH][`PCP_ABL_HI:`PCP_ABL_LO]
                : auto_backlash;
        nxt_ld_pd = act_q[`PCP_IDX_BACKLASH][`PCP_LD_PD];
    end

    // Output registers; strap lookup values follow in one cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // Defaults show until the first edge after release reloads them
            cur_ff      <= `PCP_RST_CURRENT;
            mode_ff     <= pcp_pkg::PCP_MODE_NORMAL;
            fb_edge_ff  <= 1'b0;
            ref_edge_ff <= 1'b0;
            vco_mid_ff  <= 1'b0;
            div_ff      <= `PCP_DIV_NONE;
            abl_ff      <= pcp_pkg::PCP_ABL_MINIMUM;
            ld_pd_ff    <= 1'b0;
        end else if (ce) begin
            cur_ff      <= nxt_cur;
            mode_ff     <= nxt_mode;
            fb_edge_ff  <= nxt_fb_edge;
            ref_edge_ff <= nxt_ref_edge;
            vco_mid_ff  <= nxt_vco_mid;
            div_ff      <= nxt_div;
            abl_ff      <= nxt_abl;
            ld_pd_ff    <= nxt_ld_pd;
        end
    end

    // Pump current and mode
    assign cp_current       = cur_ff;
    assign cp_mode          = mode_ff;

    // Detector edges and oscillator midscale
    assign fb_edge_falling  = fb_edge_ff;
    assign ref_edge_falling = ref_edge_ff;
    assign vco_force_mid    = vco_mid_ff;

    // Test dividers, one enable per detector clock
    assign div_fb           = div_ff[`PCP_DIV_FB];
    assign div_ref          = div_ff[`PCP_DIV_REF];
    assign div_up           = div_ff[`PCP_DIV_UP];
    assign div_dn           = div_ff[`PCP_DIV_DN];

    // Backlash period and lock detector
    assign backlash_sel     = abl_ff;
    assign lock_det_pd      = ld_pd_ff;

endmodule : pcp_regs
`default_nettype wire

// ---- pcp_regs_sva.sv ----
// Port checker for the pump and detector control bank
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module pcp_regs_sva (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       ce,
    // Register access
    input wire logic       reg_rd,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       reg_hit,
    input wire logic       io_update,
    // Pin-driven values and analog controls
    input wire logic [7:0] pin_table_current,
    input wire logic [1:0] auto_backlash,
    input wire logic [7:0] cp_current,
    input wire logic [1:0] cp_mode,
    input wire logic [1:0] backlash_sel,
    input wire logic       div_fb,
    input wire logic       div_ref,
    input wire logic       div_up,
    input wire logic       div_dn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Offsets outside the bank must miss
    wire logic unmapped = (reg_addr < `PCP_OFS_CURRENT) || (reg_addr > `PCP_OFS_BACKLASH);

    // Reads answer exactly one cycle later, and only then
    property p_rd_answer; ce && reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_only; $past(ce) |-> reg_rvalid == $past(reg_rd); endproperty
    a_rd_only: assert property (p_rd_only) else $error("answer does not match read");
    property p_miss; ce && reg_rd && unmapped |=> !reg_hit && reg_rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped read not zero");
    property p_hit; ce && reg_rd && !unmapped |=> reg_hit; endproperty
    a_hit: assert property (p_hit) else $error("mapped read missed");
    property p_idle_zero; !reg_rvalid |-> reg_rdata == 8'h00 && !reg_hit; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
    // The all-divide code is the only one that divides pump-down
    property p_div_all; div_dn |-> div_fb && div_up && !div_ref; endproperty
    a_div_all: assert property (p_div_all) else $error("bad divider set");
    // Outputs move only two edges after an update or reset, or one edge after a pin-side change
    property p_mode_upd; $changed(cp_mode) |-> $past(io_update, 2); endproperty
    a_mode_upd: assert property (p_mode_upd) else $error("mode moved without update");
    property p_cur_cause;
        $changed(cp_current) |-> $past(io_update, 2) || !$past(rst_n, 2) ||
            ($past(pin_table_current) != $past(pin_table_current, 2));
    endproperty
    a_cur_cause: assert property (p_cur_cause) else $error("current moved unprompted");
    property p_abl_cause;
        $changed(backlash_sel) |-> $past(io_update, 2) || !$past(rst_n, 2) ||
            ($past(auto_backlash) != $past(auto_backlash, 2));
    endproperty
    a_abl_cause: assert property (p_abl_cause) else $error("backlash moved unprompted");
endmodule : pcp_regs_sva

bind pcp_regs pcp_regs_sva pcp_regs_sva_inst (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .ce                (ce),
    .reg_rd            (reg_rd),
    .reg_addr          (reg_addr),
    .reg_rdata         (reg_rdata),
    .reg_rvalid        (reg_rvalid),
    .reg_hit           (reg_hit),
    .io_update         (io_update),
    .pin_table_current (pin_table_current),
    .auto_backlash     (auto_backlash),
    .cp_current        (cp_current),
    .cp_mode           (cp_mode),
    .backlash_sel      (backlash_sel),
    .div_fb            (div_fb),
    .div_ref           (div_ref),
    .div_up            (div_up),
    .div_dn            (div_dn)
);
`default_nettype wire

// ---- pcp_regs_tb.sv ----
// Self-checking bench for the pump and detector control bank
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module testbench;
    // Design stimulus and observed outputs
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic io_update = 1'b0, readback_buffered = 1'b0, reg_hit, reg_rvalid, lock_det_pd;
    logic fb_edge_falling, ref_edge_falling, vco_force_mid, div_fb, div_ref, div_up, div_dn;
    logic [12:0] reg_addr = 13'h0000;
    logic [7:0] reg_wdata = 8'h00, pin_table_current = 8'h80, reg_rdata, cp_current;
    logic [1:0] auto_backlash = 2'h0, cp_mode, backlash_sel;
    int fail_count = 0, num_checks = 0, cycles = 0;

    pcp_regs pcp_regs_inst (
        .mclk              (mclk),
        .rst_n             (rst_n),
        .ce                (ce),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .reg_rvalid        (reg_rvalid),
        .reg_hit           (reg_hit),
        .io_update         (io_update),
        .readback_buffered (readback_buffered),
        .pin_table_current (pin_table_current),
        .auto_backlash     (auto_backlash),
        .cp_current        (cp_current),
        .cp_mode           (cp_mode),
        .fb_edge_falling   (fb_edge_falling),
        .ref_edge_falling  (ref_edge_falling),
        .vco_force_mid     (vco_force_mid),
        .div_fb            (div_fb),
        .div_ref           (div_ref),
        .div_up            (div_up),
        .div_dn            (div_dn),
        .backlash_sel      (backlash_sel),
        .lock_det_pd       (lock_det_pd)
    );

    always #5 mclk = ~mclk;

    // Verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // Hang guard, far above the 165 or so cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run;
        end
    end

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Inputs always move 1 ns after the edge
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task wr(input logic [12:0] a, input logic [7:0] d);
        step(1);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
    endtask : wr

    // Answer stands only in the cycle after the taking edge
    task rd(input logic [12:0] a, input logic [7:0] exp, input logic hit);
        step(1);
        chk("idle rvalid", {7'h00, reg_rvalid}, 8'h00);
        reg_rd = 1'b1; reg_addr = a;
        step(1);
        reg_rd = 1'b0;
        chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
        chk("rdata", reg_rdata, exp);
        chk("hit", {7'h00, reg_hit}, {7'h00, hit});
    endtask : rd

    // Write, update, then wait the one cycle the outputs lag the actives
    task prog(input logic [12:0] a, input logic [7:0] d);
        wr(a, d);
        step(1);
        io_update = 1'b1;
        step(1);
        io_update = 1'b0;
        step(1);
    endtask : prog

    // Main sequence
    initial begin
        step(8);
        rst_n = 1'b1;
        step(2);
        chk("cp_current", cp_current, 8'h80);
        chk("cp_mode", {6'h00, cp_mode}, 8'h03);
        chk("controls", {fb_edge_falling, ref_edge_falling, vco_force_mid, div_fb, div_ref,
            div_up, div_dn, lock_det_pd}, 8'h00);
        rd(`PCP_OFS_CURRENT, 8'h80, 1'b1);
        rd(`PCP_OFS_CONTROL, 8'h30, 1'b1);
        rd(`PCP_OFS_TESTDIV, 8'h00, 1'b1);
        rd(`PCP_OFS_BACKLASH, 8'h00, 1'b1);
        // Strap lookup and automatic backlash drive outputs while overrides are off
        pin_table_current = 8'h3C;
        auto_backlash = 2'h2;
        step(2);
        chk("strap current", cp_current, 8'h3C);
        chk("auto backlash", {6'h00, backlash_sel}, 8'h02);
        // Buffered writes stay hidden until update
        wr(`PCP_OFS_CURRENT, 8'hC5);
        wr(`PCP_OFS_CONTROL, 8'hB0);
        wr(`PCP_OFS_TESTDIV, 8'hFF);
        wr(`PCP_OFS_BACKLASH, 8'hFF);
        wr(13'h000E, 8'hFF);
        chk("held current", cp_current, 8'h3C);
        rd(`PCP_OFS_CURRENT, 8'h80, 1'b1);
        readback_buffered = 1'b1;
        rd(`PCP_OFS_CURRENT, 8'hC5, 1'b1);
        rd(`PCP_OFS_TESTDIV, 8'h07, 1'b1);
        rd(`PCP_OFS_BACKLASH, 8'hC1, 1'b1);
        rd(13'h000E, 8'h00, 1'b0);
        prog(`PCP_OFS_CURRENT, 8'hC5);
        chk("code current", cp_current, 8'hC5);
        chk("auto kept", {6'h00, backlash_sel}, 8'h02);
        chk("lock pd", {7'h00, lock_det_pd}, 8'h01);
        // Every mode code, then the disable bit over normal mode
        for (int i = 0; i < 4; i++) begin
            prog(`PCP_OFS_CONTROL, {2'b10, i[1:0], 4'h0});
            chk("mode", {6'h00, cp_mode}, {6'h00, i[1:0]});
        end
        prog(`PCP_OFS_CONTROL, 8'hB8);
        chk("disabled mode", {6'h00, cp_mode}, 8'h00);
        // Edge selects and midscale, one bit at a time
        for (int i = 0; i < 3; i++) begin
            prog(`PCP_OFS_CONTROL, 8'hB0 | (8'h01 << i));
            chk("edges", {5'h00, fb_edge_falling, ref_edge_falling, vco_force_mid},
                8'h01 << i);
        end
        // Every test divider code
        for (int i = 0; i < 8; i++) begin
            prog(`PCP_OFS_TESTDIV, {5'h00, i[2:0]});
            chk("dividers", {4'h0, div_fb, div_ref, div_up, div_dn},
                (i == 7) ? 8'h0B : {4'h0, i[0], i[1], i[2], 1'b0});
        end
        // Programmed backlash periods with lock detector toggling
        prog(`PCP_OFS_CONTROL, 8'hF0);
        for (int i = 0; i < 4; i++) begin
            prog(`PCP_OFS_BACKLASH, {i[1:0], 5'h00, i[0]});
            chk("backlash", {6'h00, backlash_sel}, {6'h00, i[1:0]});
            chk("lock pd", {7'h00, lock_det_pd}, {7'h00, i[0]});
        end
        // Clock enable low must swallow the write, the update and any output move
        ce = 1'b0;
        prog(`PCP_OFS_CURRENT, 8'h11);
        ce = 1'b1;
        step(2);
        chk("frozen current", cp_current, 8'hC5);
        rd(`PCP_OFS_CURRENT, 8'hC5, 1'b1);
        // Reset in mid-run restores defaults; strap and automatic values reload
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(2);
        chk("reset current", cp_current, 8'h3C);
        chk("reset mode", {6'h00, cp_mode}, 8'h03);
        chk("reset backlash", {6'h00, backlash_sel}, 8'h02);
        chk("reset lock pd", {7'h00, lock_det_pd}, 8'h00);
        rd(`PCP_OFS_CONTROL, 8'h30, 1'b1);
        complete_run;
    end
endmodule : testbench
`default_nettype wire
